/* File: core/brc_pkg.sv */
// Package: register map, codes, timing and carrier types for the brownout reset block
package brc_pkg;
  localparam logic [3:0] ADDR_THRESHOLD   = 4'h0;
  localparam logic [3:0] ADDR_CAUSE       = 4'h1;
  localparam logic [3:0] ADDR_WDOG_CTRL   = 4'h2;
  localparam logic [3:0] ADDR_GUARD       = 4'h3;
  localparam logic [3:0] ADDR_STATUS      = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK    = 4'h6;

  localparam logic [7:0] THR_2V10         = 8'h55;
  localparam logic [7:0] THR_2V55         = 8'h33;
  localparam logic [7:0] THR_3V15         = 8'h99;
  localparam logic [7:0] THR_3V80         = 8'hAA;
  localparam logic [7:0] THR_RESET       = 8'h55;

  localparam logic [7:0] GUARD_CODE_A     = 8'h55;
  localparam logic [7:0] GUARD_CODE_B     = 8'hAA;
  localparam logic [7:0] GUARD_RESET      = 8'h55;

  localparam logic [4:0] WDOG_ENABLE      = 5'h0A;
  localparam logic [4:0] WDOG_DISABLE     = 5'h15;
  localparam logic [4:0] WDOG_RESET       = 5'h0A;

  localparam int CAUSE_WDOG_BIT           = 0;
  localparam int CAUSE_THR_BIT            = 1;
  localparam int CAUSE_BOR_BIT            = 2;
  localparam int CAUSE_GUARD_BIT          = 3;
  localparam int STAT_TIMEOUT_BIT         = 0;
  localparam int STAT_PWRDN_BIT           = 1;

  localparam int CLK_HZ                   = 40_000_000;
  localparam int QUALIFY_TIME_NS          = 1000;
  localparam int SOFT_DELAY_NS            = 500;
  localparam int QUALIFY_CYCLES           = (QUALIFY_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SOFT_DELAY_CYCLES        = (SOFT_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PULSE_CYCLES             = 4;

  typedef struct packed {
    logic timeout_wdog;
    logic sleeping;
  } brc_wdog_evt_t;

  typedef struct packed {
    logic full_reset;
    logic core_reset;
  } brc_reset_out_t;
endpackage : brc_pkg

/* File: core/brc_qualify.sv */
// Holds a low-supply indication until it has lasted past the qualify count
module brc_qualify
  import brc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic enable_i,
  input  wire logic low_i,
  output logic      qualified_o
);
  logic [7:0] count;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !enable_i || !low_i)
    begin
      count       <= 8'h00;
      qualified_o <= 1'b0;
    end
    else if (count < 8'(QUALIFY_CYCLES))
    begin
      count       <= count + 8'h01;
      qualified_o <= 1'b0;
    end
    else
    begin
      qualified_o <= 1'b1;
    end
  end

  a_short_low_ignored : assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(qualified_o) |-> $past(low_i, 1) && $past(low_i, 2))
    else $error("brownout qualified without sustained low");
endmodule : brc_qualify

/* File: core/brc_top.sv */
// Brownout reset, register guards, reset cause flags and watchdog status flags
module brc_top
  import brc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        low_supply_i,
  input  wire logic        sleep_mode_i,
  input  wire logic        wdog_timeout_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [7:0]  dat_i,
  input  wire logic        sel_i,
  output logic [7:0]       dat_o,
  output logic             ack_o,
  output logic             system_reset_o,
  output logic             pc_sp_clear_o,
  output logic             wdog_enable_o,
  output logic [7:0]       threshold_o,
  output logic             irq_o
);
  // Counted from the first pending cycle, the fire cycle lies one short of the full delay
  localparam int SOFT_GAP = SOFT_DELAY_CYCLES - 1;

  logic [2:0]     low_sync;
  logic           low_level;
  logic           brownout_hit;
  logic [7:0]     threshold;
  logic [7:0]     guard;
  logic [4:0]     wdog_code;
  logic [3:0]     cause;
  logic [1:0]     status;
  logic [3:0]     irq_status;
  logic [3:0]     irq_mask;
  logic [7:0]     soft_count;
  logic           soft_pending;
  logic [2:0]     pulse_count;
  brc_reset_out_t rst_req;
  brc_wdog_evt_t  wevt;
  logic           wr;
  logic           rd_cycle;
  logic           thr_bad;
  logic           guard_bad;
  logic           wdog_bad;
  logic           soft_fire;
  logic           soft_reset_src;

  function automatic logic thr_valid(input logic [7:0] v);
    thr_valid = (v == THR_2V10) || (v == THR_2V55) || (v == THR_3V15) || (v == THR_3V80);
  endfunction : thr_valid

  assign wr        = cyc_i && stb_i && we_i && sel_i && !ack_o;
  assign rd_cycle  = cyc_i && stb_i && !ack_o;
  assign thr_bad   = !thr_valid(threshold);
  assign guard_bad = (guard != GUARD_CODE_A) && (guard != GUARD_CODE_B);
  assign wdog_bad  = (wdog_code != WDOG_ENABLE) && (wdog_code != WDOG_DISABLE);
  assign wevt.timeout_wdog = wdog_timeout_i;
  assign wevt.sleeping     = sleep_mode_i;
  assign soft_fire = soft_pending && (soft_count == 8'(SOFT_DELAY_CYCLES - 1));

  // Three-stage sampler; a change counts once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      low_sync  <= 3'h0;
      low_level <= 1'b0;
    end
    else
    begin
      low_sync <= {low_sync[1:0], low_supply_i};
      if (low_sync[1] == low_sync[2])
      begin
        low_level <= low_sync[2];
      end
    end
  end

  brc_qualify u_qualify (
    .clk_i       (clk_i),
    .rst_i       (rst_i || system_reset_o),
    .enable_i    (!sleep_mode_i),
    .low_i       (low_level),
    .qualified_o (brownout_hit)
  );

  // Soft reset delay: latched at detection so the register restore cannot cancel it
  always_ff @(posedge clk_i)
  begin
    if (rst_i || system_reset_o)
    begin
      soft_pending   <= 1'b0;
      soft_count     <= 8'h00;
      soft_reset_src <= 1'b0;
    end
    else if (!soft_pending)
    begin
      if (thr_bad || guard_bad || wdog_bad)
      begin
        soft_pending   <= 1'b1;
        soft_reset_src <= thr_bad;
      end
    end
    else if (!soft_fire)
    begin
      soft_count <= soft_count + 8'h01;
    end
  end

  // Request decode: full resets stretch the reset output, sleep time-out only clears PC and SP
  always_comb
  begin
    rst_req.full_reset = brownout_hit || soft_fire || (wevt.timeout_wdog && !wevt.sleeping);
    rst_req.core_reset = wevt.timeout_wdog && wevt.sleeping;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      system_reset_o <= 1'b1;
      pulse_count    <= 3'(PULSE_CYCLES - 1);
      pc_sp_clear_o  <= 1'b1;
    end
    else
    begin
      pc_sp_clear_o <= rst_req.core_reset || rst_req.full_reset;
      if (rst_req.full_reset)
      begin
        system_reset_o <= 1'b1;
        pulse_count    <= 3'(PULSE_CYCLES - 1);
      end
      else if (pulse_count != 3'h0)
      begin
        pulse_count <= pulse_count - 3'h1;
      end
      else
      begin
        system_reset_o <= 1'b0;
      end
    end
  end

  // Threshold: kept across brownout, restored only by power-on or its own bad value
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      threshold <= THR_RESET;
    end
    else if (soft_fire && soft_reset_src)
    begin
      threshold <= THR_RESET;
    end
    else if (wr && adr_i == ADDR_THRESHOLD)
    begin
      threshold <= dat_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || (soft_fire && !brownout_hit))
    begin
      guard     <= GUARD_RESET;
      wdog_code <= WDOG_RESET;
    end
    else if (wr && adr_i == ADDR_GUARD)
    begin
      guard <= dat_i;
    end
    else if (wr && adr_i == ADDR_WDOG_CTRL)
    begin
      wdog_code <= dat_i[4:0];
    end
  end

  // Cause flags: set wins over a software clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cause <= 4'h0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (wr && adr_i == ADDR_CAUSE && !dat_i[i])
        begin
          cause[i] <= 1'b0;
        end
      end
      if (brownout_hit)
      begin
        cause[CAUSE_BOR_BIT] <= 1'b1;
      end
      if (soft_pending && !soft_fire && thr_bad)
      begin
        cause[CAUSE_THR_BIT] <= 1'b1;
      end
      if (soft_pending && guard_bad)
      begin
        cause[CAUSE_GUARD_BIT] <= 1'b1;
      end
      if (soft_pending && wdog_bad)
      begin
        cause[CAUSE_WDOG_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status <= 2'h0;
    end
    else if (wevt.timeout_wdog)
    begin
      status[STAT_TIMEOUT_BIT] <= 1'b1;
      if (wevt.sleeping)
      begin
        status[STAT_PWRDN_BIT] <= 1'b1;
      end
    end
  end

  // Interrupt status mirrors cause events; write one clears, set wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_status <= 4'h0;
      irq_mask   <= 4'h0;
    end
    else
    begin
      irq_status <= (irq_status & ~((wr && adr_i == ADDR_IRQ_STATUS) ? dat_i[3:0] : 4'h0))
                  | {soft_pending && guard_bad, brownout_hit,
                     soft_pending && thr_bad, soft_pending && wdog_bad};
      if (wr && adr_i == ADDR_IRQ_MASK)
      begin
        irq_mask <= dat_i[3:0];
      end
    end
  end

  assign irq_o         = |(irq_status & irq_mask);
  assign wdog_enable_o = (wdog_code == WDOG_ENABLE);
  assign threshold_o   = threshold;

  // Bus slave: one-cycle ack, unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 8'h00;
    end
    else
    begin
      ack_o <= rd_cycle;
      dat_o <= 8'h00;
      if (rd_cycle)
      begin
        unique case (adr_i)
          ADDR_THRESHOLD:  dat_o <= threshold;
          ADDR_CAUSE:      dat_o <= {4'h0, cause};
          ADDR_WDOG_CTRL:  dat_o <= {3'h0, wdog_code};
          ADDR_GUARD:      dat_o <= guard;
          ADDR_STATUS:     dat_o <= {6'h00, status};
          ADDR_IRQ_STATUS: dat_o <= {4'h0, irq_status};
          ADDR_IRQ_MASK:   dat_o <= {4'h0, irq_mask};
          default:         dat_o <= 8'h00;
        endcase
      end
    end
  end

  a_brownout_flag : assert property (@(posedge clk_i) disable iff (rst_i)
    brownout_hit |=> cause[CAUSE_BOR_BIT])
    else $error("brownout flag not set");
  a_sleep_no_bor : assert property (@(posedge clk_i) disable iff (rst_i)
    sleep_mode_i |=> !brownout_hit)
    else $error("brownout qualified in sleep");
  a_thr_restore : assert property (@(posedge clk_i) disable iff (rst_i)
    (soft_fire && soft_reset_src) |=> threshold == THR_RESET && system_reset_o)
    else $error("threshold not restored");
  a_thr_flag : assert property (@(posedge clk_i) disable iff (rst_i || system_reset_o)
    (soft_pending && thr_bad && !soft_fire) |=> cause[CAUSE_THR_BIT])
    else $error("threshold flag not set");
  a_thr_kept : assert property (@(posedge clk_i) disable iff (rst_i)
    (brownout_hit && !soft_fire && !wr) |=> $stable(threshold))
    else $error("threshold changed by brownout");
  a_upper_zero : assert property (@(posedge clk_i) disable iff (rst_i)
    (ack_o && $past(adr_i) == ADDR_CAUSE) |-> dat_o[7:4] == 4'h0)
    else $error("cause upper bits not zero");
  a_wdog_normal : assert property (@(posedge clk_i) disable iff (rst_i)
    (wdog_timeout_i && !sleep_mode_i) |=> system_reset_o && status[STAT_TIMEOUT_BIT])
    else $error("normal timeout not handled");
  a_wdog_sleep : assert property (@(posedge clk_i) disable iff (rst_i)
    (wdog_timeout_i && sleep_mode_i && !brownout_hit && !soft_fire && !system_reset_o)
      |=> pc_sp_clear_o && status == 2'h3 && !system_reset_o)
    else $error("sleep timeout not handled");
  a_soft_delay : assert property (@(posedge clk_i) disable iff (rst_i || system_reset_o)
    $rose(soft_pending) |-> !soft_fire [*1] ##SOFT_GAP soft_fire)
    else $error("soft reset delay wrong");
  a_por_outputs : assert property (@(posedge clk_i)
    rst_i |=> system_reset_o && pc_sp_clear_o && threshold == THR_RESET && !ack_o && !irq_o)
    else $error("power-on state wrong");
  a_wdog_flag : assert property (@(posedge clk_i) disable iff (rst_i)
    (soft_pending && wdog_bad) |=> cause[CAUSE_WDOG_BIT])
    else $error("watchdog code flag not set");
  a_guard_flag : assert property (@(posedge clk_i) disable iff (rst_i)
    (soft_pending && guard_bad) |=> cause[CAUSE_GUARD_BIT])
    else $error("guard flag not set");
  a_status_kept : assert property (@(posedge clk_i) disable iff (rst_i)
    (brownout_hit && !wdog_timeout_i) |=> $stable(status))
    else $error("status changed by brownout");
  a_flag_sticky : assert property (@(posedge clk_i) disable iff (rst_i)
    (cause[CAUSE_BOR_BIT] && !(wr && adr_i == ADDR_CAUSE)) |=> cause[CAUSE_BOR_BIT])
    else $error("brownout flag lost");
endmodule : brc_top

/* File: tb/tb_brc_top.sv */
// Self-checking testbench for the brownout reset and cause flag block
module tb_brc_top import brc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       low = 1'b0;
  logic       slp = 1'b0;
  logic       wto = 1'b0;
  logic       cyc = 1'b0;
  logic       stb = 1'b0;
  logic       we = 1'b0;
  logic       sel = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [7:0] wd = 8'h00;
  logic [7:0] dat, thr, q;
  logic       ack, srst, pcsp, wden, irq;
  int         n_mismatch = 0;
  int         n_checks = 0;

  always #12.5 clk_i = ~clk_i;

  brc_top u_brc_top (.clk_i(clk_i), .rst_i(rst_i), .low_supply_i(low), .sleep_mode_i(slp),
    .wdog_timeout_i(wto), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wd), .sel_i(sel),
    .dat_o(dat), .ack_o(ack), .system_reset_o(srst), .pc_sp_clear_o(pcsp), .wdog_enable_o(wden),
    .threshold_o(thr), .irq_o(irq));

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic hang(input string what);
    n_mismatch++;
    $display("BAD %s expected event seen timeout", what);
    test_done();
  endtask : hang

  // Entered just after a rising edge; holds the request until ack is sampled
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    sel <= 1'b1;
    we  <= w;
    adr <= a;
    wd  <= d;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    if (k >= 20)
      hang("bus ack");
    q = dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wait_rst(input logic lvl, input int lim, output int k);
    k = 0;
    while (srst !== lvl)
    begin
      @(posedge clk_i);
      k++;
      if (k > lim)
        hang("system reset");
    end
  endtask : wait_rst

  task automatic t_por();
    chk("threshold pin", thr, 8'h55);
    bus(1'b0, ADDR_THRESHOLD, 8'h00);
    chk("threshold reg", q, 8'h55);
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk("status", q, 8'h00);
    bus(1'b1, ADDR_CAUSE, 8'hFF);
    bus(1'b0, ADDR_CAUSE, 8'h00);
    chk("cause", q, 8'h00);
    bus(1'b0, 4'hF, 8'h00);
    chk("unmapped", q, 8'h00);
    $display("power-on test done");
  endtask : t_por

  task automatic t_codes();
    logic [7:0] c [4] = '{THR_2V10, THR_2V55, THR_3V80, THR_3V15};
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, ADDR_THRESHOLD, c[i]);
      bus(1'b0, ADDR_THRESHOLD, 8'h00);
      chk("threshold code", q, c[i]);
    end
    bus(1'b1, ADDR_WDOG_CTRL, 8'(WDOG_DISABLE));
    chk("wdog off", {7'h00, wden}, 8'h00);
    repeat (30) @(posedge clk_i);
    chk("no reset", {7'h00, srst}, 8'h00);
    $display("valid code test done");
  endtask : t_codes

  task automatic t_soft();
    logic [3:0] a [3] = '{ADDR_THRESHOLD, ADDR_WDOG_CTRL, ADDR_GUARD};
    logic [7:0] v [3] = '{8'h12, 8'h03, 8'h00};
    int         b [3] = '{CAUSE_THR_BIT, CAUSE_WDOG_BIT, CAUSE_GUARD_BIT};
    int         k;
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, a[i], v[i]);
      wait_rst(1'b1, 40, k);
      // Window is loose by a few cycles for the bus handshake overhead
      chk("soft delay", 8'(k > SOFT_DELAY_CYCLES - 5 && k < SOFT_DELAY_CYCLES + 5), 8'h01);
      wait_rst(1'b0, 20, k);
      bus(1'b0, ADDR_CAUSE, 8'h00);
      chk("cause flag", q, 8'h01 << b[i]);
      bus(1'b1, ADDR_CAUSE, 8'h00);
      bus(1'b0, ADDR_CAUSE, 8'h00);
      chk("cause clear", q, 8'h00);
    end
    chk("threshold back", thr, THR_RESET);
    chk("wdog back", {7'h00, wden}, 8'h01);
    $display("soft reset test done");
  endtask : t_soft

  task automatic t_wdog();
    int k;
    wto <= 1'b1;
    @(posedge clk_i);
    wto <= 1'b0;
    wait_rst(1'b1, 10, k);
    wait_rst(1'b0, 20, k);
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk("status normal", q, 8'h01);
    slp <= 1'b1;
    wto <= 1'b1;
    @(posedge clk_i);
    wto <= 1'b0;
    k = 0;
    while (pcsp !== 1'b1 && k < 6)
    begin
      @(posedge clk_i);
      k++;
    end
    chk("pc sp clear", {7'h00, pcsp}, 8'h01);
    repeat (10) @(posedge clk_i);
    chk("no reset sleep", {7'h00, srst}, 8'h00);
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk("status sleep", q, 8'h03);
    slp <= 1'b0;
    $display("watchdog test done");
  endtask : t_wdog

  task automatic t_bor();
    int k;
    low <= 1'b1;
    repeat (20) @(posedge clk_i);
    low <= 1'b0;
    repeat (60) @(posedge clk_i);
    chk("short low", {7'h00, srst}, 8'h00);
    slp <= 1'b1;
    low <= 1'b1;
    repeat (90) @(posedge clk_i);
    chk("low in sleep", {7'h00, srst}, 8'h00);
    low <= 1'b0;
    repeat (6) @(posedge clk_i);
    slp <= 1'b0;
    low <= 1'b1;
    wait_rst(1'b1, 80, k);
    chk("qualify time", 8'(k > QUALIFY_CYCLES), 8'h01);
    low <= 1'b0;
    wait_rst(1'b0, 20, k);
    chk("threshold kept", thr, THR_3V15);
    bus(1'b0, ADDR_CAUSE, 8'h00);
    chk("brownout flag", q, 8'h04);
    bus(1'b0, ADDR_STATUS, 8'h00);
    chk("status kept", q, 8'h03);
    $display("brownout test done");
  endtask : t_bor

  task automatic t_irq();
    bus(1'b1, ADDR_IRQ_MASK, 8'h00);
    chk("irq masked", {7'h00, irq}, 8'h00);
    bus(1'b1, ADDR_IRQ_MASK, 8'h04);
    chk("irq raised", {7'h00, irq}, 8'h01);
    bus(1'b1, ADDR_IRQ_STATUS, 8'h04);
    chk("irq cleared", {7'h00, irq}, 8'h00);
    bus(1'b1, ADDR_IRQ_MASK, 8'h0B);
    chk("irq soft events", {7'h00, irq}, 8'h01);
    bus(1'b1, ADDR_IRQ_STATUS, 8'h0F);
    bus(1'b0, ADDR_IRQ_STATUS, 8'h00);
    chk("irq status", q, 8'h00);
    chk("irq idle", {7'h00, irq}, 8'h00);
    $display("interrupt test done");
  endtask : t_irq

  initial
  begin
    int k;
    repeat (20) @(posedge clk_i);
    chk("reset outputs", {6'h00, srst, pcsp}, 8'h03);
    rst_i <= 1'b0;
    wait_rst(1'b0, 10, k);
    t_por();
    t_codes();
    t_soft();
    t_wdog();
    bus(1'b1, ADDR_THRESHOLD, THR_3V15);
    t_bor();
    t_irq();
    test_done();
  end
endmodule : tb_brc_top
